// ===== inc/wfd_consts.vh
// Purpose: constants of the inverter frequency and duty controller
// Assumes: 250 MHz core clock, frequency held in Hz, duty in 0.1 % steps
// Notes:   register byte offsets on a 32-bit APB slave, one word each
`ifndef WFD_CONSTS_VH
`define WFD_CONSTS_VH

// =====================================================================
// register offsets
`define WFD_REG_CTRL    8'h00
`define WFD_REG_TARGET  8'h04
`define WFD_REG_SSMIN   8'h08
`define WFD_REG_STEP    8'h0c
`define WFD_REG_STATUS  8'h10
`define WFD_REG_FREQ    8'h14
`define WFD_REG_DUTY    8'h18
`define WFD_REG_CUR     8'h1c

// =====================================================================
// control fields and reset values
`define WFD_CTRL_EN_BIT     0
`define WFD_CTRL_FASSIST_BIT 1
`define WFD_CTRL_RST        2'h2
`define WFD_TARGET_RST      16'h00c8
`define WFD_SSMIN_RST       8'h40
`define WFD_STEP_RST        18'h01388

// =====================================================================
// operating ranges, frequency in Hz, duty in 0.1 % units
`define WFD_FMIN_HZ    18'h1adb0
`define WFD_FMAX_HZ    18'h320c8
`define WFD_FPING_HZ   18'h25d78
`define WFD_DMIN       9'h014
`define WFD_DMAX       9'h1f4
`define WFD_DPING      9'h12c
`define WFD_PID_LIMIT  16'h4e20

// =====================================================================
// timing
`define WFD_CLK_MHZ       250
`define WFD_PING_WAIT_US  70
`define WFD_OFF_WAIT_US   100

`endif

// ===== logic/wfd_sat.v
// Purpose: signed add with saturation to a closed range
// Assumes: lo_in not above hi_in
// Notes:   combinational, used for both frequency and duty
`timescale 1ns/100ps
`default_nettype none

module wfd_sat #(
  parameter W = 20
) (
  input  wire signed [W-1:0] base_in,
  input  wire signed [W-1:0] delta_in,
  input  wire signed [W-1:0] lo_in,
  input  wire signed [W-1:0] hi_in,
  output reg  signed [W-1:0] val_out,
  output reg                 sat_out
);

  wire signed [W:0] sum = {base_in[W-1], base_in} + {delta_in[W-1], delta_in};

  // clip the sum at both ends and flag a clip
  always @* begin
    val_out = sum[W-1:0];
    sat_out = 1'b0;
    // signed casts keep a negative sum from comparing as a huge unsigned value
    if (sum < $signed({lo_in[W-1], lo_in})) begin
      val_out = lo_in;
      sat_out = 1'b1;
    end else if (sum > $signed({hi_in[W-1], hi_in})) begin
      val_out = hi_in;
      sat_out = 1'b1;
    end
  end

endmodule // wfd_sat

`default_nettype wire

// ===== logic/wfd_ctrl.v
// Purpose: ping, retry and PID power control of a full-bridge inverter
// Assumes: strength and current inputs come from logic on CLK_IN
// Notes:   APB slave answers with one wait state
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "wfd_consts.vh"

module wfd_ctrl #(
  parameter [31:0] PING_WAIT_CYC = `WFD_PING_WAIT_US * `WFD_CLK_MHZ,
  parameter [31:0] OFF_WAIT_CYC  = `WFD_OFF_WAIT_US * `WFD_CLK_MHZ
) (
  input  wire        CLK_IN,
  input  wire        RESETN_IN,
  input  wire        PSEL_IN,
  input  wire        PENABLE_IN,
  input  wire        PWRITE_IN,
  input  wire [7:0]  PADDR_IN,
  input  wire [31:0] PWDATA_IN,
  output reg  [31:0] PRDATA_OUT,
  output reg         PREADY_OUT,
  output reg         PSLVERR_OUT,
  input  wire        SS_VALID_IN,
  input  wire [7:0]  SS_VALUE_IN,
  input  wire        CUR_VALID_IN,
  input  wire [15:0] CUR_MA_IN,
  output reg         POWER_ON_OUT,
  output reg  [17:0] OPERATING_FREQUENCY_OUT,
  output reg  [8:0]  DUTY_OUT
);

  // =====================================================================
  // states
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_PING = 4'b0010;
  localparam [3:0] ST_OFF  = 4'b0100;
  localparam [3:0] ST_XFER = 4'b1000;

  // =====================================================================
  // registers
  reg  [1:0]  ctrl_q;
  reg  [15:0] target_q;
  reg  [7:0]  ssmin_q;
  reg  [17:0] step_q;
  reg  [3:0]  state_q;
  reg  [3:0]  state_d;
  reg  [31:0] cnt_q;
  reg  [31:0] cnt_d;
  reg  [17:0] ping_f_q;
  reg  [17:0] ping_f_d;
  reg  [7:0]  retries_q;
  reg  [7:0]  retries_d;
  reg  [15:0] cur_q;
  reg  [17:0] freq_d;
  reg  [8:0]  duty_d;
  reg         power_d;
  reg  [31:0] rdata;
  reg         mapped;

  wire enable      = ctrl_q[`WFD_CTRL_EN_BIT];
  wire f_assist    = ctrl_q[`WFD_CTRL_FASSIST_BIT];
  wire apb_req     = PSEL_IN & PENABLE_IN;
  wire apb_done    = apb_req & PREADY_OUT;

  // =====================================================================
  // apb slave: one wait state, data and error registered with ready
  always @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= 32'h0000_0000;
    end else begin
      PREADY_OUT  <= apb_req & ~PREADY_OUT;
      PSLVERR_OUT <= apb_req & ~PREADY_OUT & ~mapped;
      if (apb_req & ~PREADY_OUT & ~PWRITE_IN) begin
        PRDATA_OUT <= rdata;
      end
    end
  end

  // read mux, unused bits read as zero
  always @* begin
    rdata  = 32'h0000_0000;
    mapped = 1'b1;
    case (PADDR_IN)
      `WFD_REG_CTRL:   rdata = {30'h0000_0000, ctrl_q};
      `WFD_REG_TARGET: rdata = {16'h0000, target_q};
      `WFD_REG_SSMIN:  rdata = {24'h00_0000, ssmin_q};
      `WFD_REG_STEP:   rdata = {14'h0000, step_q};
      `WFD_REG_STATUS: rdata = {16'h0000, retries_q, 3'h0, POWER_ON_OUT, state_q};
      `WFD_REG_FREQ:   rdata = {14'h0000, OPERATING_FREQUENCY_OUT};
      `WFD_REG_DUTY:   rdata = {23'h00_0000, DUTY_OUT};
      `WFD_REG_CUR:    rdata = {16'h0000, cur_q};
      default:         mapped = 1'b0;
    endcase
  end

  // =====================================================================
  // software writable registers, written at the completing edge
  always @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ctrl_q   <= `WFD_CTRL_RST;
      target_q <= `WFD_TARGET_RST;
      ssmin_q  <= `WFD_SSMIN_RST;
      step_q   <= `WFD_STEP_RST;
    end else if (apb_done & PWRITE_IN) begin
      case (PADDR_IN)
        `WFD_REG_CTRL:   ctrl_q   <= PWDATA_IN[1:0];
        `WFD_REG_TARGET: target_q <= PWDATA_IN[15:0];
        `WFD_REG_SSMIN:  ssmin_q  <= PWDATA_IN[7:0];
        `WFD_REG_STEP:   step_q   <= PWDATA_IN[17:0];
        default:         ctrl_q   <= ctrl_q;
      endcase
    end
  end

  // =====================================================================
  // current feedback, kept at 1 mA resolution
  always @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cur_q <= 16'h0000;
    end else if (CUR_VALID_IN) begin
      cur_q <= CUR_MA_IN;
    end
  end

  // =====================================================================
  // proportional term: measured minus target, positive means too much power
  wire signed [16:0] err = $signed({1'b0, CUR_MA_IN}) - $signed({1'b0, target_q});
  wire signed [16:0] lim_p = $signed({1'b0, `WFD_PID_LIMIT});
  wire signed [16:0] lim_n = -lim_p;
  reg  signed [16:0] pid;

  // gain 1, integral and derivative zero, output clamped
  always @* begin
    pid = err;
    if (err > lim_p) begin
      pid = lim_p;
    end else if (err < lim_n) begin
      pid = lim_n;
    end
  end

  // scale: +1 Hz per unit for frequency, -0.1 % per unit for duty
  wire signed [19:0] f_delta = {{3{pid[16]}}, pid};
  wire signed [19:0] d_delta = -{{3{pid[16]}}, pid};

  wire signed [19:0] f_new;
  wire signed [19:0] d_new;
  wire               f_sat;
  wire               d_sat;

  // frequency correction saturated to its range
  wfd_sat #(.W(20)) u_fsat (
    .base_in  ({2'b00, OPERATING_FREQUENCY_OUT}),
    .delta_in (f_delta),
    .lo_in    ({2'b00, `WFD_FMIN_HZ}),
    .hi_in    ({2'b00, `WFD_FMAX_HZ}),
    .val_out  (f_new),
    .sat_out  (f_sat)
  );

  // duty correction saturated to its range
  wfd_sat #(.W(20)) u_dsat (
    .base_in  ({11'h000, DUTY_OUT}),
    .delta_in (d_delta),
    .lo_in    ({11'h000, `WFD_DMIN}),
    .hi_in    ({11'h000, `WFD_DMAX}),
    .val_out  (d_new),
    .sat_out  (d_sat)
  );

  // =====================================================================
  // next retry frequency: step down, back to the start below the floor
  wire [18:0] floor_room = {1'b0, step_q} + {1'b0, `WFD_FMIN_HZ};
  wire        wrap       = ({1'b0, ping_f_q} < floor_room);
  wire [17:0] f_lower    = ping_f_q - step_q;
  wire        ss_ok      = SS_VALID_IN & (SS_VALUE_IN >= ssmin_q);

  // =====================================================================
  // sequence: ping, withdraw and retry, then closed-loop transfer
  always @* begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    ping_f_d  = ping_f_q;
    retries_d = retries_q;
    freq_d    = OPERATING_FREQUENCY_OUT;
    duty_d    = DUTY_OUT;
    power_d   = POWER_ON_OUT;
    case (state_q)
      ST_IDLE: begin
        power_d  = 1'b0;
        ping_f_d = `WFD_FPING_HZ;
        if (enable) begin
          state_d   = ST_PING;
          cnt_d     = 32'h0000_0000;
          retries_d = 8'h00;
          freq_d    = `WFD_FPING_HZ;
          duty_d    = `WFD_DPING;
          power_d   = 1'b1;
        end
      end
      ST_PING: begin
        cnt_d = cnt_q + 32'h0000_0001;
        if (ss_ok) begin
          state_d = ST_XFER;
        end else if (cnt_q >= PING_WAIT_CYC - 32'h0000_0001) begin
          state_d = ST_OFF;
          cnt_d   = 32'h0000_0000;
          power_d = 1'b0;
        end
      end
      ST_OFF: begin
        cnt_d = cnt_q + 32'h0000_0001;
        if (cnt_q >= OFF_WAIT_CYC - 32'h0000_0001) begin
          state_d   = ST_PING;
          cnt_d     = 32'h0000_0000;
          ping_f_d  = wrap ? `WFD_FPING_HZ : f_lower;
          freq_d    = ping_f_d;
          duty_d    = `WFD_DPING;
          retries_d = retries_q + 8'h01;
          power_d   = 1'b1;
        end
      end
      ST_XFER: begin
        if (CUR_VALID_IN) begin
          duty_d = d_new[8:0];
          if (d_sat & f_assist) begin
            freq_d = f_new[17:0];
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        power_d = 1'b0;
      end
    endcase
    if (!enable) begin
      state_d = ST_IDLE;
      power_d = 1'b0;
    end
  end

  // state and inverter command flip-flops, frequency in 1 Hz steps
  always @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_q                 <= ST_IDLE;
      cnt_q                   <= 32'h0000_0000;
      ping_f_q                <= `WFD_FPING_HZ;
      retries_q               <= 8'h00;
      POWER_ON_OUT            <= 1'b0;
      OPERATING_FREQUENCY_OUT <= `WFD_FPING_HZ;
      DUTY_OUT                <= `WFD_DPING;
    end else begin
      state_q                 <= state_d;
      cnt_q                   <= cnt_d;
      ping_f_q                <= ping_f_d;
      retries_q               <= retries_d;
      POWER_ON_OUT            <= power_d;
      OPERATING_FREQUENCY_OUT <= freq_d;
      DUTY_OUT                <= duty_d;
    end
  end

endmodule // wfd_ctrl

`default_nettype wire

// ===== test/wfd_ctrl_asserts.sv
// Purpose: port level checks of wfd_ctrl
// Assumes: strength threshold left at its reset value
// Notes:   bound to the design from tb_top
`timescale 1ns/100ps
`default_nettype none
`include "wfd_consts.vh"
module wfd_ctrl_asserts #(
  parameter int PING_WAIT_CYC = 17500
) (
  input wire logic        CLK_IN,
  input wire logic        RESETN_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        SS_VALID_IN,
  input wire logic [7:0]  SS_VALUE_IN,
  input wire logic        CUR_VALID_IN,
  input wire logic        POWER_ON_OUT,
  input wire logic [17:0] OPERATING_FREQUENCY_OUT,
  input wire logic [8:0]  DUTY_OUT
);
  logic [15:0] on_cnt_q;
  logic        heard_q;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // ====
  // power-on time and whether a strong answer came
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      on_cnt_q <= 16'h0;
      heard_q <= 1'b0;
    end else begin
      on_cnt_q <= POWER_ON_OUT ? on_cnt_q + 16'h1 : 16'h0;
      heard_q <= POWER_ON_OUT & (heard_q | (SS_VALID_IN & (SS_VALUE_IN >= 8'h40)));
    end
  end
  sequence s_access;
    $rose(PENABLE_IN) && PSEL_IN;
  endsequence
  sequence s_answer;
    !PREADY_OUT ##1 PREADY_OUT;
  endsequence
  // ====
  // assertions
  a_freq_range: assert property (OPERATING_FREQUENCY_OUT >= `WFD_FMIN_HZ
    && OPERATING_FREQUENCY_OUT <= `WFD_FMAX_HZ) else $error("frequency out of range");
  a_duty_range: assert property (DUTY_OUT >= `WFD_DMIN
    && DUTY_OUT <= `WFD_DMAX) else $error("duty out of range");
  a_apb_wait: assert property (s_access |-> s_answer) else $error("ready not in 2nd access");
  a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready too long");
  a_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT) else $error("error without ready");
  a_ping_start: assert property ($rose(POWER_ON_OUT) |-> DUTY_OUT == `WFD_DPING
    && OPERATING_FREQUENCY_OUT <= `WFD_FPING_HZ) else $error("bad ping settings");
  a_ping_drop: assert property (heard_q || on_cnt_q <= PING_WAIT_CYC + 3)
    else $error("ping not withdrawn");
  a_off_hold: assert property ($fell(POWER_ON_OUT) |-> !POWER_ON_OUT [*8])
    else $error("off time too short");
  a_duty_cause: assert property (POWER_ON_OUT && $past(POWER_ON_OUT) && $changed(DUTY_OUT)
    |-> $past(CUR_VALID_IN) || $past(CUR_VALID_IN, 2)) else $error("duty moved unasked");
  a_duty_first: assert property (POWER_ON_OUT && $past(POWER_ON_OUT)
    && $changed(OPERATING_FREQUENCY_OUT) |-> DUTY_OUT == `WFD_DMIN || DUTY_OUT == `WFD_DMAX)
    else $error("frequency moved before duty limit");
endmodule // wfd_ctrl_asserts
`default_nettype wire

// ===== test/wfd_rx_model.sv
// Purpose: receiver that answers a ping with a strength packet
// Assumes: answer five cycles after power is applied
// Notes:   value lines show the inverse when no packet is sent
`timescale 1ns/100ps
`default_nettype none
module wfd_rx_model (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       power_in,
  input  wire logic       arm_in,
  input  wire logic [7:0] value_in,
  output var  logic       ss_valid_out,
  output var  logic [7:0] ss_value_out
);
  logic [7:0] on_cnt_q;
  // count cycles since the power signal appeared
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) on_cnt_q <= 8'h0;
    else on_cnt_q <= power_in ? on_cnt_q + {7'h0, on_cnt_q != 8'hff} : 8'h0;
  end
  // one packet per ping, well inside the ping time
  assign ss_valid_out = arm_in & power_in & (on_cnt_q == 8'h05);
  assign ss_value_out = ss_valid_out ? value_in : ~value_in;
endmodule // wfd_rx_model
`default_nettype wire

// ===== test/tb_top.sv
// Purpose: register, ping and loop tests of wfd_ctrl
// Assumes: short ping 20 and off 30 cycles
// Notes:   expectations worked out from the ranges and steps
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk, rst_n, psel, pen, pwr, ssv, curv, arm, pready, perr, pwr_on, err;
  logic [7:0]  paddr, ssval, rxval;
  logic [31:0] pwd, prd, rd;
  logic [15:0] cur;
  logic [17:0] freq;
  logic [8:0]  duty;
  int error_cnt = 0;
  int n_compared = 0;
  logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  logic [31:0] rv [7] = '{32'h2, 32'hc8, 32'h40, 32'h1388, 32'h1, 32'h25d78, 32'h12c};
  logic [15:0] pc [8] = '{16'h12c, 16'h64, 16'h7530, 16'h7530, 16'h7530, 0, 0, 0};
  logic [8:0]  pd [8] = '{9'hc8, 9'h12c, 9'h14, 9'h14, 9'h14, 9'hdc, 9'h1a4, 9'h1f4};
  logic [17:0] pf [8] = '{18'h249f0, 18'h249f0, 18'h29810, 18'h2e630, 18'h320c8,
                          18'h320c8, 18'h320c8, 18'h32000};
  wfd_ctrl #(.PING_WAIT_CYC(32'd20), .OFF_WAIT_CYC(32'd30)) wfd_ctrl_inst (.CLK_IN(clk),
    .RESETN_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(pready), .PSLVERR_OUT(perr),
    .SS_VALID_IN(ssv), .SS_VALUE_IN(ssval), .CUR_VALID_IN(curv), .CUR_MA_IN(cur),
    .POWER_ON_OUT(pwr_on), .OPERATING_FREQUENCY_OUT(freq), .DUTY_OUT(duty));
  wfd_rx_model wfd_rx_model_inst (.clk_in(clk), .resetn_in(rst_n), .power_in(pwr_on),
    .arm_in(arm), .value_in(rxval), .ss_valid_out(ssv), .ss_value_out(ssval));
  // ====
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task close_out;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      close_out;
    end
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wpw(input logic v);
    int n;
    n = 0;
    while (pwr_on !== v && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (pwr_on !== v) begin
      error_cnt++;
      close_out;
    end
  endtask
  // one current sample, then look at the settled outputs
  task pid(input logic [15:0] c, input logic [8:0] ed, input logic [17:0] ef);
    @(posedge clk);
    curv <= 1'b1;
    cur <= c;
    @(posedge clk);
    curv <= 1'b0;
    repeat (3) @(posedge clk);
    chk("duty", ed, duty);
    chk("freq", ef, freq);
  endtask
  // ====
  // main sequence
  initial begin
    {psel, pen, pwr, curv, arm} = 5'h0;
    {paddr, rxval, pwd, cur} = 64'h0;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", rv[i], rd);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, rd);
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("ro freq", 32'h25d78, rd);
    $display("test registers done");
    arm <= 1'b1;
    rxval <= 8'h10;
    apb(1'b1, 8'h00, 32'h3);
    wpw(1'b1);
    chk("ping freq", 32'h25d78, {14'h0, freq});
    chk("ping duty", 32'h12c, {23'h0, duty});
    wpw(1'b0);
    chk("withdrawn", 32'h0, {31'h0, pwr_on});
    rxval <= 8'h80;
    wpw(1'b1);
    chk("retry freq", 32'h249f0, {14'h0, freq});
    repeat (40) @(posedge clk);
    apb(1'b0, 8'h10, 32'h0);
    chk("status", 32'h118, rd);
    $display("test ping done");
    foreach (pc[i]) pid(pc[i], pd[i], pf[i]);
    apb(1'b1, 8'h00, 32'h1);
    pid(16'h0, 9'h1f4, 18'h32000);
    apb(1'b1, 8'h00, 32'h0);
    wpw(1'b0);
    apb(1'b0, 8'h10, 32'h0);
    chk("idle", 32'h101, rd);
    pid(16'h12d, 9'h1f4, 18'h32000);
    apb(1'b0, 8'h1c, 32'h0);
    chk("current", 32'h12d, rd);
    $display("test loop done");
    close_out;
  end
endmodule // tb_top
bind wfd_ctrl wfd_ctrl_asserts #(.PING_WAIT_CYC(PING_WAIT_CYC)) wfd_ctrl_asserts_inst (
  .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .SS_VALID_IN(SS_VALID_IN),
  .SS_VALUE_IN(SS_VALUE_IN), .CUR_VALID_IN(CUR_VALID_IN), .POWER_ON_OUT(POWER_ON_OUT),
  .OPERATING_FREQUENCY_OUT(OPERATING_FREQUENCY_OUT), .DUTY_OUT(DUTY_OUT));
`default_nettype wire
